/* File: shared/ebcu_defs.svh */
// Purpose: Opcodes, status bit positions and reset values for the endpoint command unit
// Assumes: One 8-bit command code per command phase
// Notes: Definitions only, included by bare name
`ifndef EBCU_DEFS_SVH
`define EBCU_DEFS_SVH

// Endpoint count and control endpoint numbers
`define EBCU_NUM_EP 16
`define EBCU_EP_CTRL_OUT 4'h0
`define EBCU_EP_CTRL_IN 4'h1
`define EBCU_CTRL_MASK 16'h0003
`define EBCU_ONE_HOT_EP 16'h0001

// High nibble of endpoint commands
`define EBCU_OP_STALL 4'h4
`define EBCU_OP_RDST 4'h5
`define EBCU_OP_VALID 4'h6
`define EBCU_OP_CLEAR 4'h7
`define EBCU_OP_UNSTALL 4'h8
`define EBCU_OP_CHECK 4'hd

// Whole-code commands
`define EBCU_CODE_ACK 8'hf4

// Status byte bit positions
`define EBCU_BIT_HALT 7
`define EBCU_BIT_FULL1 6
`define EBCU_BIT_FULL0 5
`define EBCU_BIT_TOGGLE 4
`define EBCU_BIT_CLOB 3
`define EBCU_BIT_SETUP 2
`define EBCU_BIT_CPUSEL 1
`define EBCU_BIT_RSV 0

// Reset values
`define EBCU_STATUS_RST 8'h00
`define EBCU_VEC_RST 16'h0000

`endif

/* File: shared/ebcu_pkg.sv */
// Purpose: Types shared by the endpoint command unit
// Assumes: Nothing beyond the defs header
// Notes: Command kinds are one-hot
package ebcu_pkg;

  // Decoded command kind
  typedef enum logic [7:0] {
    EBCU_K_NONE    = 8'h01,
    EBCU_K_STALL   = 8'h02,
    EBCU_K_UNSTALL = 8'h04,
    EBCU_K_VALID   = 8'h08,
    EBCU_K_CLEAR   = 8'h10,
    EBCU_K_READ    = 8'h20,
    EBCU_K_CHECK   = 8'h40,
    EBCU_K_ACK     = 8'h80
  } ebcu_kind_t;

  // Endpoint status byte
  typedef logic [7:0] ebcu_status_t;

endpackage

/* File: verilog/ebcu_decode.sv */
// Purpose: Turns a command code into a command kind and endpoint number
// Assumes: Code is valid only in the cycle cmd_valid is high
// Notes: Codes outside the handled set decode to none
`timescale 1ns/1ps
`default_nettype none
`include "ebcu_defs.svh"

module ebcu_decode
  import ebcu_pkg::*;
(
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  output var ebcu_kind_t kind,
  output logic [3:0] ep_idx
);

  logic [3:0] op;
  logic is_ack;
  logic valid_ok;
  logic clear_ok;

  // Opcode split and holes in the validate and clear ranges
  assign op = cmd_code[7:4];
  assign ep_idx = cmd_code[3:0];
  assign is_ack = cmd_code == `EBCU_CODE_ACK;
  assign valid_ok = ep_idx != `EBCU_EP_CTRL_OUT;
  assign clear_ok = ep_idx != `EBCU_EP_CTRL_IN;

  // Priority chain from code to kind
  assign kind = !cmd_valid ? EBCU_K_NONE :
                is_ack ? EBCU_K_ACK :
                (op == `EBCU_OP_STALL) ? EBCU_K_STALL :
                (op == `EBCU_OP_UNSTALL) ? EBCU_K_UNSTALL :
                (op == `EBCU_OP_VALID && valid_ok) ? EBCU_K_VALID :
                (op == `EBCU_OP_CLEAR && clear_ok) ? EBCU_K_CLEAR :
                (op == `EBCU_OP_RDST) ? EBCU_K_READ :
                (op == `EBCU_OP_CHECK) ? EBCU_K_CHECK :
                EBCU_K_NONE;

endmodule
`default_nettype wire

/* File: verilog/ebcu_ep.sv */
// Purpose: Halt, buffer-full, toggle and buffer-select state of one endpoint
// Assumes: At most one command strobe per cycle
// Notes: Direction-free; fill and drain come from CPU or SIE side
`timescale 1ns/1ps
`default_nettype none

module ebcu_ep (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dbl,
  input wire logic stall,
  input wire logic unstall,
  input wire logic cpu_fill,
  input wire logic cpu_drain,
  input wire logic sie_fill,
  input wire logic sie_drain,
  output logic halted,
  output logic [1:0] full,
  output logic toggle,
  output logic cpu_sel,
  output logic out_nak,
  output logic in_ready,
  output logic reinit
);

  logic halt_r, halt_nxt;
  logic [1:0] full_r, full_nxt;
  logic tog_r, tog_nxt;
  logic cs_r, cs_nxt;
  logic ss_r, ss_nxt;
  logic rein_r, rein_nxt;

  // Next state: release, halt, then buffer events in order
  always_comb begin
    halt_nxt = halt_r;
    full_nxt = full_r;
    tog_nxt = tog_r;
    cs_nxt = cs_r;
    ss_nxt = ss_r;
    rein_nxt = 1'b0;
    if (unstall && halt_r) begin
      halt_nxt = 1'b0;
      rein_nxt = 1'b1;
      full_nxt = 2'b00;
      tog_nxt = 1'b0;
      cs_nxt = 1'b0;
      ss_nxt = 1'b0;
    end
    if (stall) begin
      halt_nxt = 1'b1;
    end
    if (cpu_fill) begin
      full_nxt[cs_nxt] = 1'b1;
      cs_nxt = cs_nxt ^ dbl;
    end
    if (cpu_drain) begin
      full_nxt[cs_nxt] = 1'b0;
      cs_nxt = cs_nxt ^ dbl;
    end
    if (sie_fill && !full_nxt[ss_nxt]) begin
      full_nxt[ss_nxt] = 1'b1;
      tog_nxt = ~tog_nxt;
      ss_nxt = ss_nxt ^ dbl;
    end
    if (sie_drain && full_nxt[ss_nxt]) begin
      full_nxt[ss_nxt] = 1'b0;
      tog_nxt = ~tog_nxt;
      ss_nxt = ss_nxt ^ dbl;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      halt_r <= 1'b0;
      full_r <= 2'b00;
      tog_r <= 1'b0;
      cs_r <= 1'b0;
      ss_r <= 1'b0;
      rein_r <= 1'b0;
    end else begin
      halt_r <= halt_nxt;
      full_r <= full_nxt;
      tog_r <= tog_nxt;
      cs_r <= cs_nxt;
      ss_r <= ss_nxt;
      rein_r <= rein_nxt;
    end
  end

  // Outputs seen by the status byte and the SIE
  assign halted = halt_r;
  assign full = full_r;
  assign toggle = tog_r;
  assign cpu_sel = cs_r;
  assign out_nak = full_r[ss_r];
  assign in_ready = full_r[ss_r] && !halt_r;
  assign reinit = rein_r;

endmodule
`default_nettype wire

/* File: verilog/ebcu_core.sv */
// Purpose: Endpoint command unit: executes per-endpoint commands from the CPU port
// Assumes: Command strobe and SIE events arrive on clk from same-clock logic
// Notes: Status answers one cycle after the command; FIFO data is handled elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "ebcu_defs.svh"

// Operation
// - Codes 0x40-0x4F set the addressed endpoint's halted flag; no data phase.
// - Codes 0x80-0x8F clear the addressed endpoint's halted flag; no data phase.
// - A SETUP token releases a halted control endpoint regardless of content.
// - Releasing a halted endpoint flushes its buffer and resets its toggle to DATA0.
// - Codes 0x61-0x6F mark the IN buffer full and swap CPU buffer if double.
// - A full IN buffer is sent on the next IN token for that endpoint.
// - Codes 0x70, 0x72-0x7F empty the OUT buffer and swap CPU buffer if double.
// - A complete received OUT packet sets that endpoint's buffer-full flag.
// - A full locked OUT buffer answers further packets with NAK until cleared.
// - Codes 0xD0-0xDF return the status byte and clear nothing.
// - Status byte: halt, full1, full0, toggle, clobbered, setup, cpu select, zero.
// - Toggle bit reads 0 for DATA0 next and 1 for DATA1 next.
// - CPU select bit reads 0 for primary buffer and 1 for secondary.
// - New SETUP over unacknowledged setup sets clobbered; a finished-write read clears it.
// - A received SETUP blocks validate and clear on both control endpoints.
// - Code 0xF4 acknowledges setup and unblocks control validate and clear.
// - Codes 0x50-0x5F return the status byte and clear the endpoint interrupt bit.
module ebcu_core
  import ebcu_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] ep_double,
  input wire logic sie_setup,
  input wire logic sie_setup_busy,
  input wire logic sie_out_done,
  input wire logic sie_in_done,
  input wire logic [3:0] sie_ep,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic cmd_refused,
  output logic [15:0] irq_clear,
  output logic setup_locked,
  output logic [15:0] ep_halted,
  output logic [15:0] ep_toggle,
  output logic [15:0] ep_out_nak,
  output logic [15:0] ep_in_ready,
  output logic [15:0] ep_reinit
);

  localparam int NUM_EP = `EBCU_NUM_EP;

  ebcu_kind_t kind;
  logic [3:0] idx;
  logic [15:0] sel;
  logic [15:0] sie_sel;
  logic is_ctrl;
  logic is_ep0;
  logic refuse;
  logic do_stall;
  logic do_unstall;
  logic do_valid;
  logic do_clear;
  logic do_read;
  logic do_check;
  logic do_ack;
  logic stall_ctrl;
  logic [15:0] stall_v;
  logic [15:0] unstall_v;
  logic [15:0] cpu_fill_v;
  logic [15:0] cpu_drain_v;
  logic [15:0] sie_fill_v;
  logic [15:0] sie_drain_v;
  logic [15:0] full0_v;
  logic [15:0] full1_v;
  logic [15:0] cpusel_v;
  ebcu_status_t rd_mux;
  logic lock_r, lock_nxt;
  logic pend_r, pend_nxt;
  logic clob_r, clob_nxt;
  logic spres_r, spres_nxt;
  logic clob_clr;
  logic rd_valid_r;
  ebcu_status_t rd_data_r;
  logic refused_r;
  logic [15:0] irq_clear_r;

  // Command decode
  ebcu_decode u_decode (
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .kind(kind),
    .ep_idx(idx)
  );

  // Endpoint selection from command and SIE numbers
  assign sel = `EBCU_ONE_HOT_EP << idx;
  assign sie_sel = `EBCU_ONE_HOT_EP << sie_ep;
  assign is_ctrl = idx[3:1] == 3'b000;
  assign is_ep0 = idx == `EBCU_EP_CTRL_OUT;

  // Control validate and clear are held off until setup is acknowledged
  assign refuse = lock_r && is_ctrl &&
                  (kind == EBCU_K_VALID || kind == EBCU_K_CLEAR);

  // Accepted command strobes
  assign do_stall = kind == EBCU_K_STALL;
  assign do_unstall = kind == EBCU_K_UNSTALL;
  assign do_valid = kind == EBCU_K_VALID && !refuse;
  assign do_clear = kind == EBCU_K_CLEAR && !refuse;
  assign do_read = kind == EBCU_K_READ;
  assign do_check = kind == EBCU_K_CHECK;
  assign do_ack = kind == EBCU_K_ACK;
  assign stall_ctrl = do_stall && is_ctrl;

  // Per-endpoint strobe vectors
  assign stall_v = do_stall ? sel : `EBCU_VEC_RST;
  assign unstall_v = (do_unstall ? sel : `EBCU_VEC_RST) |
                     (sie_setup ? `EBCU_CTRL_MASK : `EBCU_VEC_RST);
  assign cpu_fill_v = do_valid ? sel : `EBCU_VEC_RST;
  assign cpu_drain_v = do_clear ? sel : `EBCU_VEC_RST;
  assign sie_fill_v = sie_out_done ? sie_sel : `EBCU_VEC_RST;
  assign sie_drain_v = sie_in_done ? sie_sel : `EBCU_VEC_RST;

  // One state block per endpoint
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
      ebcu_ep u_ep (
        .clk(clk),
        .resetn(resetn),
        .dbl(ep_double[g]),
        .stall(stall_v[g]),
        .unstall(unstall_v[g]),
        .cpu_fill(cpu_fill_v[g]),
        .cpu_drain(cpu_drain_v[g]),
        .sie_fill(sie_fill_v[g]),
        .sie_drain(sie_drain_v[g]),
        .halted(ep_halted[g]),
        .full({full1_v[g], full0_v[g]}),
        .toggle(ep_toggle[g]),
        .cpu_sel(cpusel_v[g]),
        .out_nak(ep_out_nak[g]),
        .in_ready(ep_in_ready[g]),
        .reinit(ep_reinit[g])
      );
    end
  endgenerate

  // Setup interlock and setup flags; a new SETUP wins over any clear
  assign clob_clr = do_read && is_ep0 && !sie_setup_busy;
  assign lock_nxt = sie_setup | (lock_r & ~do_ack);
  assign pend_nxt = sie_setup | (pend_r & ~do_ack & ~stall_ctrl);
  assign clob_nxt = (sie_setup & pend_r) | (clob_r & ~clob_clr);
  assign spres_nxt = sie_setup | (spres_r & ~(do_clear & is_ep0));

  // Status byte of the addressed endpoint
  assign rd_mux = {ep_halted[idx], full1_v[idx], full0_v[idx], ep_toggle[idx],
                   clob_r & is_ep0, spres_r & is_ep0, cpusel_v[idx], 1'b0};

  // Setup flag registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_r <= 1'b0;
      pend_r <= 1'b0;
      clob_r <= 1'b0;
      spres_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      pend_r <= pend_nxt;
      clob_r <= clob_nxt;
      spres_r <= spres_nxt;
    end
  end

  // Answer registers for the command port
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= `EBCU_STATUS_RST;
      refused_r <= 1'b0;
      irq_clear_r <= `EBCU_VEC_RST;
    end else begin
      rd_valid_r <= do_read | do_check;
      if (do_read || do_check) begin
        rd_data_r <= rd_mux;
      end
      refused_r <= refuse;
      irq_clear_r <= do_read ? sel : `EBCU_VEC_RST;
    end
  end

  // Outputs
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign cmd_refused = refused_r;
  assign irq_clear = irq_clear_r;
  assign setup_locked = lock_r;

  // Stall command halts the addressed endpoint
  chk_stall_sets_halt: assert property (@(posedge clk) disable iff (!resetn)
    do_stall |=> ep_halted[$past(idx)])
    else $error("stall command did not halt endpoint");

  // Unstall command releases the addressed endpoint
  chk_unstall_clears: assert property (@(posedge clk) disable iff (!resetn)
    do_unstall |=> !ep_halted[$past(idx)])
    else $error("unstall command left endpoint halted");

  // SETUP releases both control endpoints unless re-halted at once
  chk_setup_releases: assert property (@(posedge clk) disable iff (!resetn)
    (sie_setup && !stall_ctrl) |=> (ep_halted[1:0] == 2'b00))
    else $error("setup did not release control endpoints");

  // A release of a halted endpoint reinitialises it in the same edge
  chk_release_reinit: assert property (@(posedge clk) disable iff (!resetn)
    $fell(ep_halted[2]) |-> (ep_reinit[2] && !ep_toggle[2] && !ep_out_nak[2]))
    else $error("released endpoint not reinitialised");

  // Validate on a single-buffered endpoint makes it ready to send
  chk_validate_ready: assert property (@(posedge clk) disable iff (!resetn)
    (do_valid && !ep_double[idx] && !sie_in_done && !ep_halted[idx])
    |=> ep_in_ready[$past(idx)])
    else $error("validated buffer not ready");

  // Locked OUT buffer keeps answering NAK while no clear arrives
  chk_nak_holds: assert property (@(posedge clk) disable iff (!resetn)
    (ep_out_nak[2] && !cmd_valid && !(sie_in_done && sie_ep == 4'h2))
    |=> ep_out_nak[2])
    else $error("locked buffer stopped answering nak");

  // Check status answers next cycle with no interrupt clear
  chk_check_quiet: assert property (@(posedge clk) disable iff (!resetn)
    do_check |=> (rd_valid && irq_clear == 16'h0000 && rd_data == $past(rd_mux)))
    else $error("check status answer wrong or destructive");

  // Destructive read clears exactly the addressed interrupt bit
  chk_read_irq: assert property (@(posedge clk) disable iff (!resetn)
    do_read |=> (rd_valid && irq_clear == (16'h0001 << $past(idx))))
    else $error("status read did not clear its interrupt bit");

  // Reserved status bit reads zero and halt bit tracks the endpoint
  chk_status_layout: assert property (@(posedge clk) disable iff (!resetn)
    (do_check && !do_stall) |=> (rd_data[0] == 1'b0 && rd_data[7] == $past(ep_halted[idx])))
    else $error("status byte layout wrong");

  // Control clear under the setup lock is refused
  chk_lock_refuses: assert property (@(posedge clk) disable iff (!resetn)
    (lock_r && is_ctrl && kind == EBCU_K_CLEAR)
    |=> (cmd_refused && $stable(full0_v[1:0])))
    else $error("locked control clear was not refused");

  // Acknowledge unlocks unless a new SETUP arrives together
  chk_ack_unlocks: assert property (@(posedge clk) disable iff (!resetn)
    (do_ack && !sie_setup) |=> !setup_locked)
    else $error("acknowledge did not unlock");

  // SETUP over unacknowledged setup data marks it clobbered
  chk_clobber_sets: assert property (@(posedge clk) disable iff (!resetn)
    (sie_setup && pend_r) |=> clob_r ##1 (clob_r || $past(clob_clr)))
    else $error("overwritten setup not flagged");

  // A received SETUP locks control validate and clear
  chk_setup_locks: assert property (@(posedge clk) disable iff (!resetn)
    sie_setup |=> setup_locked)
    else $error("setup did not lock control commands");

  // A double-buffered validate or clear swaps the CPU buffer
  chk_sel_swaps: assert property (@(posedge clk) disable iff (!resetn)
    ((do_valid || do_clear) && ep_double[idx] && !sie_setup)
    |=> (cpusel_v[$past(idx)] != $past(cpusel_v[idx])))
    else $error("double buffer select did not swap");

  // A complete OUT packet into an empty single buffer marks it full
  chk_out_fills: assert property (@(posedge clk) disable iff (!resetn)
    (sie_out_done && !ep_double[sie_ep] && !ep_out_nak[sie_ep] && !sie_in_done && !cmd_valid)
    |=> ep_out_nak[$past(sie_ep)])
    else $error("received packet did not fill buffer");

  // A sent IN packet empties a single buffer
  chk_in_drains: assert property (@(posedge clk) disable iff (!resetn)
    (sie_in_done && !ep_double[sie_ep] && ep_in_ready[sie_ep] && !sie_out_done && !cmd_valid)
    |=> !ep_in_ready[$past(sie_ep)])
    else $error("sent buffer still ready");

  // No command, no answer, no refusal and no interrupt clear
  chk_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !cmd_valid |=> (!rd_valid && !cmd_refused && irq_clear == 16'h0000))
    else $error("answer without a command");

  // Unstall of a halted endpoint flushes toggle and buffer select
  chk_unstall_reinit: assert property (@(posedge clk) disable iff (!resetn)
    (do_unstall && ep_halted[idx] && !sie_out_done && !sie_in_done)
    |=> (ep_reinit[$past(idx)] && !ep_toggle[$past(idx)] && !cpusel_v[$past(idx)]))
    else $error("unstalled endpoint not reinitialised");

  // Setup bits read zero on every endpoint but control OUT
  chk_setup_bits_ep0: assert property (@(posedge clk) disable iff (!resetn)
    ((do_check || do_read) && !is_ep0) |=> (rd_data[3:2] == 2'b00))
    else $error("setup bits shown on wrong endpoint");

  // A finished-write destructive read clears the clobbered flag
  chk_clobber_clears: assert property (@(posedge clk) disable iff (!resetn)
    (clob_clr && !sie_setup) |=> !clob_r)
    else $error("clobbered flag not cleared by read");

endmodule
`default_nettype wire

/* File: verification/ebcu_fw_model.sv */
// Purpose: Firmware-side model that issues command phases to the endpoint command unit
// Assumes: One command phase per call, driven on the falling clock edge
// Notes: Released code lines show the inverse of the last code
`timescale 1ns/1ps
`default_nettype none

module ebcu_fw_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);
  // Idle command port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
  end

  // One command phase, one cycle wide, then the lines are released
  task automatic issue(input logic [7:0] code);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
  endtask
endmodule

`default_nettype wire

/* File: verification/testbench.sv */
// Purpose: Self-checking bench for the endpoint command unit
// Assumes: Firmware model drives commands; bench drives SIE events on the falling edge
// Notes: Stall and unstall sweep of all 16 endpoints, then table of command, endpoint and status rows, then hand-written cases
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk;
  logic resetn;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [15:0] ep_double;
  logic sie_setup;
  logic sie_setup_busy;
  logic sie_out_done;
  logic sie_in_done;
  logic [3:0] sie_ep;
  logic rd_valid;
  logic [7:0] rd_data;
  logic cmd_refused;
  logic setup_locked;
  logic [15:0] irq_clear;
  logic [15:0] ep_halted;
  logic [15:0] ep_toggle;
  logic [15:0] ep_out_nak;
  logic [15:0] ep_in_ready;
  logic [15:0] ep_reinit;
  int error_cnt = 0;
  int total_checks = 0;
  // Rows: command code, endpoint to check, expected status byte
  logic [23:0] rows [10] = '{
    24'h43_03_80, 24'h83_03_00, 24'h4f_0f_80, 24'h8f_0f_00, 24'h63_03_20,
    24'h62_02_22, 24'h62_02_60, 24'h72_02_42, 24'h60_00_00, 24'h71_01_00};

  ebcu_core ebcu_core_inst (
    .clk(clk),
    .resetn(resetn),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code),
    .ep_double(ep_double),
    .sie_setup(sie_setup),
    .sie_setup_busy(sie_setup_busy),
    .sie_out_done(sie_out_done),
    .sie_in_done(sie_in_done),
    .sie_ep(sie_ep),
    .rd_valid(rd_valid),
    .rd_data(rd_data),
    .cmd_refused(cmd_refused),
    .irq_clear(irq_clear),
    .setup_locked(setup_locked),
    .ep_halted(ep_halted),
    .ep_toggle(ep_toggle),
    .ep_out_nak(ep_out_nak),
    .ep_in_ready(ep_in_ready),
    .ep_reinit(ep_reinit)
  );

  ebcu_fw_model ebcu_fw_model_inst (
    .clk(clk),
    .cmd_valid(cmd_valid),
    .cmd_code(cmd_code)
  );

  // 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    ebcu_fw_model_inst.issue(c);
  endtask

  // Non-destructive status read of one endpoint
  task automatic status(input logic [3:0] ep, input logic [7:0] exp);
    cmd({4'hd, ep});
    chk("rd_valid", 16'h0001, 16'(rd_valid));
    chk("rd_data", 16'(exp), 16'(rd_data));
    chk("irq_clear", 16'h0000, irq_clear);
  endtask

  // One-cycle SIE event pulse: setup, out done, in done
  task automatic sie(input logic [2:0] ev, input logic [3:0] ep);
    @(negedge clk);
    {sie_setup, sie_out_done, sie_in_done} = ev;
    sie_ep = ep;
    @(negedge clk);
    {sie_setup, sie_out_done, sie_in_done} = 3'b000;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR watchdog expected 0 seen 1");
    report_and_stop();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    ep_double = 16'h0004;
    {sie_setup, sie_out_done, sie_in_done} = 3'b000;
    sie_setup_busy = 1'b0;
    sie_ep = 4'h0;
    repeat (10) @(negedge clk);
    chk("ep_halted", 16'h0000, ep_halted);
    chk("setup_locked", 16'h0000, 16'(setup_locked));
    resetn = 1'b1;
    for (int i = 0; i < 16; i++) begin
      cmd({4'h4, 4'(i)});
      chk("ep_halted", 16'hffff >> (15 - i), ep_halted);
    end
    for (int i = 0; i < 16; i++) begin
      cmd({4'h8, 4'(i)});
      chk("ep_reinit", 16'h0001 << i, ep_reinit);
      chk("ep_halted", 16'hfffe << i, ep_halted);
    end
    foreach (rows[r]) begin
      cmd(rows[r][23:16]);
      status(rows[r][11:8], rows[r][7:0]);
    end
    // Validated IN buffer goes out on the next IN token
    chk("ep_in_ready", 16'h0001, 16'(ep_in_ready[3]));
    sie(3'b001, 4'h3);
    chk("ep_in_ready", 16'h0000, 16'(ep_in_ready[3]));
    chk("ep_toggle", 16'h0008, ep_toggle);
    status(4'h3, 8'h10);
    // OUT packet fills, further packet refused, clear reopens
    sie(3'b010, 4'h4);
    chk("ep_out_nak", 16'h0001, 16'(ep_out_nak[4]));
    status(4'h4, 8'h30);
    sie(3'b010, 4'h4);
    status(4'h4, 8'h30);
    cmd(8'h74);
    chk("ep_out_nak", 16'h0000, 16'(ep_out_nak[4]));
    status(4'h4, 8'h10);
    cmd(8'h44);
    cmd(8'h84);
    chk("ep_reinit", 16'h0010, ep_reinit);
    status(4'h4, 8'h00);
    // Destructive read clears the interrupt bit
    cmd(8'h53);
    chk("irq_clear", 16'h0008, irq_clear);
    chk("rd_data", 16'h0010, 16'(rd_data));
    status(4'h3, 8'h10);
    // Setup releases halted control endpoints and locks validate and clear
    cmd(8'h40);
    cmd(8'h41);
    sie(3'b100, 4'h0);
    chk("setup_locked", 16'h0001, 16'(setup_locked));
    chk("ep_reinit", 16'h0003, ep_reinit);
    chk("ep_halted", 16'h0000, ep_halted);
    status(4'h0, 8'h04);
    cmd(8'h61);
    chk("cmd_refused", 16'h0001, 16'(cmd_refused));
    cmd(8'h70);
    chk("cmd_refused", 16'h0001, 16'(cmd_refused));
    status(4'h1, 8'h00);
    sie_setup_busy = 1'b1;
    sie(3'b100, 4'h0);
    status(4'h0, 8'h0c);
    cmd(8'h50);
    chk("rd_data", 16'h000c, 16'(rd_data));
    status(4'h0, 8'h0c);
    sie_setup_busy = 1'b0;
    cmd(8'h50);
    status(4'h0, 8'h04);
    cmd(8'hf4);
    chk("setup_locked", 16'h0000, 16'(setup_locked));
    cmd(8'h61);
    chk("cmd_refused", 16'h0000, 16'(cmd_refused));
    status(4'h1, 8'h20);
    // Firmware re-halts a control endpoint released by setup
    cmd(8'h40);
    sie(3'b100, 4'h0);
    chk("ep_halted", 16'h0000, ep_halted);
    cmd(8'h40);
    chk("ep_halted", 16'h0001, ep_halted);
    // Reset in mid-run
    @(negedge clk);
    resetn = 1'b0;
    #1;
    chk("ep_halted", 16'h0000, ep_halted);
    chk("setup_locked", 16'h0000, 16'(setup_locked));
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    status(4'h0, 8'h00);
    report_and_stop();
  end
endmodule

`default_nettype wire
